//--- verilog/page_decoder_pkg.sv
// Constants and carrier types for the program page decoder
package page_decoder_pkg;

  // ----------------------------------------------------------------
  // Address widths
  // ----------------------------------------------------------------
  localparam int PC_W    = 12;               // Logical program counter
  localparam int PHYS_W  = 13;               // Four 2K pages
  localparam int PAGE_W  = 2;                // Page select field
  localparam int OFS_W   = 11;               // Offset inside a page
  localparam int DADDR_W = 8;                // Data space address
  localparam int STACK_DEPTH = 6;            // Return stack levels
  localparam int STACK_PTR_W = 3;

  // ----------------------------------------------------------------
  // Fixed addresses and pages
  // ----------------------------------------------------------------
  localparam logic [DADDR_W-1:0] PAGE_SEL_ADDR = 8'hCA;
  localparam logic [PAGE_W-1:0]  SHARED_PAGE   = 2'h1;
  localparam logic [PC_W-1:0]    RESET_VEC     = 12'hFFE;
  localparam logic [PC_W-1:0]    NMI_VEC       = 12'hFFC;
  localparam logic [PC_W-1:0]    IRQ_VEC_BASE  = 12'hFF0;
  localparam logic [PC_W-1:0]    IRQ_VEC_LAST  = 12'hFF7;
  localparam logic [PAGE_W-1:0]  PAGE_SEL_RST  = 2'h0;
  localparam logic [PC_W-1:0]    PC_RST        = 12'h000;
  localparam logic [STACK_PTR_W-1:0] SP_RST    = 3'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               wr;                  // Data space write strobe
    logic [DADDR_W-1:0] addr;
    logic [7:0]         data;
  } data_wr_s;

  typedef struct packed {
    logic              push;
    logic              pop;
    logic [PC_W-1:0]   ret_addr;
  } stack_req_s;

  typedef struct packed {
    logic [PHYS_W-1:0] phys_addr;
    logic [PAGE_W-1:0] page;
    logic              upper_half;
  } fetch_map_s;

endpackage

//--- verilog/program_page_decoder.sv
// Program space page decoder with return stack, NMI edge and reset
`timescale 1ns/1ps

module program_page_decoder (
  input  wire logic                               mclk_in,
  input  wire logic                               rst_in,
  input  wire logic                               reset_n_in,
  input  wire logic                               nmi_n_in,
  input  wire logic                               nmi_ack_in,
  input  wire page_decoder_pkg::data_wr_s         data_wr_in,
  input  wire logic                               pc_load_in,
  input  wire logic [page_decoder_pkg::PC_W-1:0]  pc_value_in,
  input  wire logic                               pc_inc_in,
  input  wire logic                               vec_irq_in,
  input  wire logic [1:0]                         vec_irq_sel_in,
  input  wire logic                               vec_nmi_in,
  input  wire page_decoder_pkg::stack_req_s       stack_req_in,
  output logic                                    core_reset_out,
  output logic                                    nmi_pending_out,
  output logic [page_decoder_pkg::PC_W-1:0]       program_counter_out,
  output page_decoder_pkg::fetch_map_s            fetch_out,
  output logic [page_decoder_pkg::PC_W-1:0]       vector_addr_out,
  output logic [page_decoder_pkg::PC_W-1:0]       stack_top_out,
  output logic                                    stack_full_out,
  output logic                                    stack_empty_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Restart, one vector fetch cycle, then normal run
  typedef enum logic [1:0] {ST_RESET, ST_VECTOR, ST_RUN} run_state_e;

  // Short local names for package widths and depth
  localparam int PC_W   = page_decoder_pkg::PC_W;
  localparam int DEPTH  = page_decoder_pkg::STACK_DEPTH;
  localparam int SPW    = page_decoder_pkg::STACK_PTR_W;
  localparam int PAGE_W = page_decoder_pkg::PAGE_W;

  // Registered state and the next value of each
  run_state_e                state_q;
  run_state_e                state_d;
  logic [PC_W-1:0]           program_counter_q;
  logic [PC_W-1:0]           program_counter_d;
  logic [PAGE_W-1:0]         program_page_select_q;
  logic [PAGE_W-1:0]         program_page_select_d;
  logic                      nmi_prev_q;
  logic                      nmi_prev_d;
  logic                      nmi_pending_q;
  logic                      nmi_pending_d;
  logic [PC_W-1:0]           stack_q [DEPTH];
  logic [PC_W-1:0]           stack_d [DEPTH];
  logic [SPW-1:0]            sp_q;
  logic [SPW-1:0]            sp_d;
  logic [PC_W-1:0]           vector_addr_q;
  page_decoder_pkg::fetch_map_s fetch_q;
  page_decoder_pkg::fetch_map_s fetch_d;

  // Decoded strobes and selections
  logic                      nmi_fall;
  logic                      sel_wr;
  logic                      do_push;
  logic                      do_pop;
  logic [PC_W-1:0]           vec_sel;

  // ----------------------------------------------------------------
  // Reset sequencing and program counter
  // ----------------------------------------------------------------
  // Vector address chosen for the next vector fetch
  always_comb begin
    if (vec_nmi_in) begin
      vec_sel = page_decoder_pkg::NMI_VEC;
    end else if (vec_irq_in) begin
      vec_sel = page_decoder_pkg::IRQ_VEC_BASE
              + {9'h000, vec_irq_sel_in, 1'b0};
    end else begin
      vec_sel = page_decoder_pkg::RESET_VEC;
    end
  end

  // Reset pin low holds the core in restart
  always_comb begin
    state_d           = state_q;
    program_counter_d = program_counter_q;
    if (!reset_n_in) begin
      state_d           = ST_RESET;
      program_counter_d = page_decoder_pkg::RESET_VEC;
    end else begin
      unique case (state_q)
        ST_RESET: begin
          state_d           = ST_VECTOR;
          program_counter_d = page_decoder_pkg::RESET_VEC;
        end
        ST_VECTOR: begin
          state_d = ST_RUN;
        end
        ST_RUN: begin
          if (vec_nmi_in || vec_irq_in) begin
            program_counter_d = vec_sel;
          end else if (pc_load_in) begin
            program_counter_d = pc_value_in;
          end else if (pc_inc_in) begin
            program_counter_d = program_counter_q + 12'h001;
          end
        end
      endcase
    end
  end

  // Run state and program counter registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q           <= ST_RESET;
      program_counter_q <= page_decoder_pkg::PC_RST;
    end else begin
      state_q           <= state_d;
      program_counter_q <= program_counter_d;
    end
  end

  // Vector address register, follows the request of each edge
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      vector_addr_q <= page_decoder_pkg::RESET_VEC;
    end else begin
      vector_addr_q <= vec_sel;
    end
  end

  // ----------------------------------------------------------------
  // Page select register
  // ----------------------------------------------------------------
  // Write-only: data writes to CAh load the low two bits
  assign sel_wr = data_wr_in.wr
               && (data_wr_in.addr == page_decoder_pkg::PAGE_SEL_ADDR);

  // Untouched by calls, interrupts and the reset pin
  always_comb begin
    program_page_select_d = program_page_select_q;
    if (sel_wr) begin
      program_page_select_d = data_wr_in.data[PAGE_W-1:0];
    end
  end

  // Reset value is PAGE_SEL_RST, page 0; software must write before use
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      program_page_select_q <= page_decoder_pkg::PAGE_SEL_RST;
    end else begin
      program_page_select_q <= program_page_select_d;
    end
  end

  // ----------------------------------------------------------------
  // Fetch address mapping
  // ----------------------------------------------------------------
  // Upper half to the shared page, lower half to the chosen page;
  // built from next values so the registered map never lags the PC
  always_comb begin
    fetch_d.upper_half = program_counter_d[PC_W-1];
    if (program_counter_d[PC_W-1]) begin
      fetch_d.page = page_decoder_pkg::SHARED_PAGE;
    end else begin
      fetch_d.page = program_page_select_d;
    end
    // Page 1 in the lower half reaches the same shared storage
    fetch_d.phys_addr = {fetch_d.page,
                         program_counter_d[PC_W-2:0]};
  end

  // Map register; reset value is the map of the reset counter
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_q.upper_half <= page_decoder_pkg::PC_RST[PC_W-1];
      fetch_q.page       <= page_decoder_pkg::PAGE_SEL_RST;
      fetch_q.phys_addr  <= {page_decoder_pkg::PAGE_SEL_RST,
                             page_decoder_pkg::PC_RST[PC_W-2:0]};
    end else begin
      fetch_q <= fetch_d;
    end
  end

  // ----------------------------------------------------------------
  // NMI falling edge capture
  // ----------------------------------------------------------------
  assign nmi_fall = nmi_prev_q && !nmi_n_in;

  // Edge sets pending; a new edge beats a same-cycle acknowledge
  always_comb begin
    nmi_prev_d    = nmi_n_in;
    nmi_pending_d = nmi_pending_q;
    if (nmi_ack_in) begin
      nmi_pending_d = 1'b0;
    end
    if (nmi_fall) begin
      nmi_pending_d = 1'b1;
    end
    if (!reset_n_in) begin
      nmi_pending_d = 1'b0;
    end
  end

  // Pin history idles high so reset gives no false edge
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      nmi_prev_q    <= 1'b1;
      nmi_pending_q <= 1'b0;
    end else begin
      nmi_prev_q    <= nmi_prev_d;
      nmi_pending_q <= nmi_pending_d;
    end
  end

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  // Push on full drops oldest entry by shifting; pop on empty ignored
  assign do_push = stack_req_in.push && !stack_req_in.pop;
  assign do_pop  = stack_req_in.pop && !stack_req_in.push && (sp_q != 3'h0);

  // Shift entries down on push, up on pop
  always_comb begin
    sp_d = sp_q;
    for (int i = 0; i < DEPTH; i++) begin
      stack_d[i] = stack_q[i];
    end
    if (do_push) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        stack_d[i] = stack_q[i-1];
      end
      stack_d[0] = stack_req_in.ret_addr;
      if (sp_q != 3'(DEPTH)) begin
        sp_d = sp_q + 3'h1;
      end
    end else if (do_pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        stack_d[i] = stack_q[i+1];
      end
      stack_d[DEPTH-1] = page_decoder_pkg::PC_RST;
      sp_d = sp_q - 3'h1;
    end
    if (!reset_n_in) begin
      sp_d = page_decoder_pkg::SP_RST;
    end
  end

  // Stack entry and pointer registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sp_q <= page_decoder_pkg::SP_RST;
      for (int i = 0; i < DEPTH; i++) begin
        stack_q[i] <= page_decoder_pkg::PC_RST;
      end
    end else begin
      sp_q <= sp_d;
      for (int i = 0; i < DEPTH; i++) begin
        stack_q[i] <= stack_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Data outputs straight from registers, flags decoded
  assign core_reset_out      = (state_q == ST_RESET);
  assign nmi_pending_out     = nmi_pending_q;
  assign program_counter_out = program_counter_q;
  assign fetch_out           = fetch_q;
  assign vector_addr_out     = vector_addr_q;
  assign stack_top_out       = stack_q[0];
  assign stack_full_out      = (sp_q == 3'(DEPTH));
  assign stack_empty_out     = (sp_q == 3'h0);

endmodule // program_page_decoder

//--- tb/prog_mem_model.sv
// Program memory model answering fetches from the decoder
`timescale 1ns/1ps
module prog_mem_model (
  input  wire page_decoder_pkg::fetch_map_s fetch_in,
  output logic [7:0]                        word_out
);
  // Each byte holds its page number and low offset bits
  assign word_out = {fetch_in.phys_addr[12:11],
                     fetch_in.phys_addr[5:0]};
endmodule // prog_mem_model

//--- tb/program_page_decoder_monitor.sv
// Port level checks bound onto the program page decoder
`timescale 1ns/1ps
module program_page_decoder_monitor (
  input wire logic                              mclk_in,
  input wire logic                              rst_in,
  input wire logic                              reset_n_in,
  input wire logic                              nmi_n_in,
  input wire page_decoder_pkg::data_wr_s        data_wr_in,
  input wire logic                              vec_nmi_in,
  input wire page_decoder_pkg::stack_req_s      stack_req_in,
  input wire logic                              core_reset_out,
  input wire logic                              nmi_pending_out,
  input wire logic [page_decoder_pkg::PC_W-1:0] program_counter_out,
  input wire page_decoder_pkg::fetch_map_s      fetch_out,
  input wire logic [page_decoder_pkg::PC_W-1:0] stack_top_out,
  input wire logic                              stack_empty_out
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  logic sel_wr;
  // Page select write seen
  assign sel_wr = data_wr_in.wr && (data_wr_in.addr == 8'hCA);
  property p_upper;
    program_counter_out[11] |-> fetch_out.upper_half && fetch_out.page == 2'h1;
  endproperty
  a_upper: assert property (p_upper) else $error("upper not shared");
  property p_phys;
    fetch_out.phys_addr == {fetch_out.page, program_counter_out[10:0]};
  endproperty
  a_phys: assert property (p_phys) else $error("bad physical");
  property p_sel;
    sel_wr ##1 !sel_wr ##1 !program_counter_out[11]
      |-> fetch_out.page == $past(data_wr_in.data[1:0], 2);
  endproperty
  a_sel: assert property (p_sel) else $error("page not taken");
  property p_keep;
    !sel_wr && !program_counter_out[11] ##1 !program_counter_out[11]
      |-> $stable(fetch_out.page);
  endproperty
  a_keep: assert property (p_keep) else $error("page moved");
  property p_nmi;
    $fell(nmi_n_in) && reset_n_in |=> nmi_pending_out;
  endproperty
  a_nmi: assert property (p_nmi) else $error("fall missed");
  property p_rstn;
    !reset_n_in |=> core_reset_out && program_counter_out == 12'hFFE
      && stack_empty_out && !nmi_pending_out;
  endproperty
  a_rstn: assert property (p_rstn) else $error("no restart");
  property p_vnmi;
    vec_nmi_in && reset_n_in && !core_reset_out && !$past(core_reset_out)
      |=> program_counter_out == 12'hFFC;
  endproperty
  a_vnmi: assert property (p_vnmi) else $error("bad nmi vector");
  property p_push;
    stack_req_in.push && !stack_req_in.pop && reset_n_in && !core_reset_out
      |=> stack_top_out == $past(stack_req_in.ret_addr) && !stack_empty_out;
  endproperty
  a_push: assert property (p_push) else $error("push lost");
  c_sel: cover property (sel_wr ##1 !sel_wr ##1 !program_counter_out[11]);
  c_nmi: cover property ($fell(nmi_n_in));
  c_upper: cover property ($rose(program_counter_out[11]));
endmodule // program_page_decoder_monitor

bind program_page_decoder program_page_decoder_monitor u_mon (
  .mclk_in(mclk_in), .rst_in(rst_in), .reset_n_in(reset_n_in),
  .nmi_n_in(nmi_n_in), .data_wr_in(data_wr_in), .vec_nmi_in(vec_nmi_in),
  .stack_req_in(stack_req_in), .core_reset_out(core_reset_out),
  .nmi_pending_out(nmi_pending_out), .fetch_out(fetch_out),
  .program_counter_out(program_counter_out), .stack_top_out(stack_top_out),
  .stack_empty_out(stack_empty_out));

//--- tb/tb_program_page_decoder.sv
// Self-checking bench for the program page decoder
`timescale 1ns/1ps
module tb_program_page_decoder;
  logic mclk_in = 1'b0, rst_in = 1'b1, rstn = 1'b1, nmi_n = 1'b1;
  logic ack = 1'b0, ld_en = 1'b0, inc = 1'b0, virq = 1'b0, vnmi = 1'b0;
  logic [1:0]                   isel = 2'h0;
  logic [11:0]                  pcv = 12'h000;
  page_decoder_pkg::data_wr_s   dw = '0;
  page_decoder_pkg::stack_req_s sr = '0;
  logic                         crst, pend, full, empty;
  logic [11:0]                  pc, vec, top;
  page_decoder_pkg::fetch_map_s fm;
  logic [7:0]                   word;
  int                           miscompares = 0, check_count = 0, cyc = 0;
  always #5 mclk_in = ~mclk_in;
  program_page_decoder u_program_page_decoder (.mclk_in(mclk_in),
    .rst_in(rst_in), .reset_n_in(rstn), .nmi_n_in(nmi_n), .nmi_ack_in(ack),
    .data_wr_in(dw), .pc_load_in(ld_en), .pc_value_in(pcv), .pc_inc_in(inc),
    .vec_irq_in(virq), .vec_irq_sel_in(isel), .vec_nmi_in(vnmi),
    .stack_req_in(sr), .core_reset_out(crst), .nmi_pending_out(pend),
    .program_counter_out(pc), .fetch_out(fm), .vector_addr_out(vec),
    .stack_top_out(top), .stack_full_out(full), .stack_empty_out(empty));
  prog_mem_model u_prog_mem_model (.fetch_in(fm), .word_out(word));
  task tick;
    @(posedge mclk_in);
    #1;
  endtask
  task chk(string n, logic [12:0] s, logic [12:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task wsel(logic [7:0] a, logic [7:0] d);
    dw = '{1'b1, a, d};
    tick;
    dw.wr = 1'b0;
  endtask
  task ld(logic [11:0] v);
    pcv = v;
    ld_en = 1'b1;
    tick;
    ld_en = 1'b0;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Cycle ceiling against a hang
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      finish_test;
    end
  end
  task test_reset;
    chk("crst", crst, 1);
    chk("empty", empty, 1);
    rst_in = 1'b0;
    tick;
    chk("pc", pc, 12'hFFE);
    chk("page", fm.page, 2'h1);
    chk("word", word, 8'h7E);
    tick;
    $display("test reset done");
  endtask
  task test_pages;
    for (int i = 0; i < 4; i++) begin
      ld(12'h800);
      wsel(8'hCA, 8'hFC | i[7:0]);
      ld(12'h123);
      chk("phys", fm.phys_addr, {i[1:0], 11'h123});
      chk("word", word, {i[1:0], 6'h23});
    end
    ld(12'h823);
    chk("phys", fm.phys_addr, {2'h1, 11'h023});
    wsel(8'hCB, 8'h00);
    ld(12'h7FF);
    chk("page", fm.page, 2'h3);
    inc = 1'b1;
    tick;
    inc = 1'b0;
    chk("pc", pc, 12'h800);
    chk("page", fm.page, 2'h1);
    ld(12'h800);
    wsel(8'hCA, 8'h02);
    ld(12'h456);
    chk("page", fm.page, 2'h2);
    $display("test pages done");
  endtask
  task test_nmi;
    nmi_n = 1'b0;
    tick;
    chk("pend", pend, 1);
    ack = 1'b1;
    tick;
    ack = 1'b0;
    chk("pend", pend, 0);
    nmi_n = 1'b1;
    chk("vec", vec, 12'hFFE);
    vnmi = 1'b1;
    tick;
    vnmi = 1'b0;
    chk("pc", pc, 12'hFFC);
    chk("vec", vec, 12'hFFC);
    for (int k = 0; k < 4; k++) begin
      isel = k[1:0];
      virq = 1'b1;
      tick;
      virq = 1'b0;
      chk("pc", pc, 12'hFF0 + 2 * k[11:0]);
      chk("vec", vec, 12'hFF0 + 2 * k[11:0]);
      tick;
    end
    $display("test nmi done");
  endtask
  task test_stack;
    wsel(8'hCA, 8'h03);
    sr.push = 1'b1;
    for (int i = 0; i < 7; i++) begin
      sr.ret_addr = 12'hA00 + i[11:0];
      tick;
    end
    sr.push = 1'b0;
    chk("full", full, 1);
    sr.pop = 1'b1;
    for (int i = 5; i > 0; i--) begin
      tick;
      chk("top", top, 12'hA00 + i[11:0]);
    end
    tick;
    chk("empty", empty, 1);
    sr.push = 1'b1;
    sr.ret_addr = 12'h555;
    tick;
    sr = '0;
    chk("empty", empty, 1);
    chk("top", top, 12'h000);
    ld(12'h123);
    chk("page", fm.page, 2'h3);
    $display("test stack done");
  endtask
  task test_rstn;
    rstn = 1'b0;
    tick;
    chk("crst", crst, 1);
    chk("pc", pc, 12'hFFE);
    rstn = 1'b1;
    tick;
    chk("crst", crst, 0);
    $display("test restart done");
  endtask
  initial begin
    repeat (5) @(posedge mclk_in);
    #1;
    test_reset;
    test_pages;
    test_nmi;
    test_stack;
    test_rstn;
    finish_test;
  end
endmodule // tb_program_page_decoder
